/* File: rtl/ckr_pkg.sv */
/*
 * constants and carrier types for the clock-enable and soft-reset block.
 * assumes a byte-addressed register port with 32-bit data.
 */
package ckr_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_IDLE_CLK_EN2 = 8'h08;
   localparam logic [7:0] OFS_PWR_RESTORE = 8'h0C;
   localparam logic [7:0] OFS_SOFT_RESET = 8'h10;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int BIT_PERIPH_CLK_ON = 2;
   localparam int BIT_OSTIMER_REFCLK_ON = 1;
   localparam int BIT_WDOG_CLK_ON = 0;
   localparam int BIT_POWER_CTRL_ON = 5;
   localparam int DLY_W = 5;
   localparam int BIT_GLOBAL_SOFT_RESET = 3;
   localparam int BIT_DSP_CFG_RUN = 2;
   localparam int BIT_DSP_RUN = 1;
   localparam int BIT_MPU_RESET = 0;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [2:0] RST_CLK_EN = 3'h4;
   localparam logic RST_POWER_CTRL_ON = 1'b1;
   localparam logic [4:0] RST_RESTORE_DELAY = 5'h1F;
   localparam logic RST_DSP_CFG_RUN = 1'b0;
   localparam logic RST_DSP_RUN = 1'b0;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_IDLE = 2'b01,
      ST_RESTORE = 2'b10
   } ckr_state_t;

   typedef struct packed {
      logic periph;
      logic refclk;
      logic wdog;
   } ckr_clk_en_t;

   typedef struct packed {
      logic periph;
      logic refclk;
      logic wdog;
   } ckr_idle_sel_t;

endpackage

/* File: rtl/ckr_restore_timer.sv */
/*
 * power-restore delay timer: counts rising edges of the memory-interface
 * reference clock after start. the reference clock arrives as a level
 * synchronous to clk_i and must be slower than half of clk_i.
 */
`timescale 1ns/10ps
module ckr_restore_timer #(
   parameter int DW = 5
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic start_i,
   input wire logic [DW-1:0] count_i,
   input wire logic ref_level_i,
   output logic busy_o,
   output logic done_o
);

   logic ref_prev_r;
   logic [DW-1:0] cnt_r;
   logic ref_rise;

   assign ref_rise = ref_level_i & ~ref_prev_r;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ref_prev_r <= 1'b0;
      end else begin
         ref_prev_r <= ref_level_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cnt_r <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            cnt_r <= count_i;
            busy_o <= 1'b1;
         end else if (busy_o && cnt_r == '0) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
         end else if (busy_o && ref_rise) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

   property restore_len_p;
      @(posedge clk_i) disable iff (!reset_n_i)
      (busy_o && cnt_r == '0 && !start_i) |=> done_o && !busy_o;
   endproperty
   delay_end_a: assert property (restore_len_p)
      else $error("restore timer did not finish at zero");

endmodule

/* File: rtl/ckr_clock_reset_ctrl.sv */
/*
 * clock-enable, power-restore and software-reset control registers.
 * assumes a plain register port (one-cycle strobes, read data next cycle)
 * and that idle, watchdog-mode and reference-clock inputs are synchronous.
 */
// Operation
// - bit 2 off stops peripheral clock; on allows idle gating; reset 1
// - bit 1 gates OS timer and reference clock together; reset 0
// - bit 0 gates timer/watchdog clock, idle gating allowed; reset 0
// - watchdog mode keeps its clock running regardless of enable or gate
// - power control bit 5 off drives flash pin low in idle; reset 1
// - five-bit delay, reference clock cycles from pin rise to restart
// - global reset bit 3 pulses system reset, self-clears, reads zero
// - bit 2 holds DSP config logic in reset; external reset forces zero
// - DSP run bit 1 low holds DSP core in reset; software sets it
// - MPU reset bit 0 pulses MPU reset, self-clears, reads zero
// - write with DSP run 0 and MPU reset 1 starts global reset
// - reserved bits ignore writes; read as zero here
// - peripheral idle select stops peripheral clock at idle entry
`timescale 1ns/10ps
module ckr_clock_reset_ctrl #(
   parameter int AW = ckr_pkg::ADDR_W
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic idle_i,
   input wire ckr_pkg::ckr_idle_sel_t idle_sel_i,
   input wire logic wdog_mode_i,
   input wire logic ext_reset_i,
   input wire logic memif_ref_clock_i,
   output ckr_pkg::ckr_clk_en_t clk_en_o,
   output logic flash_power_pin_o,
   output logic global_soft_reset_o,
   output logic mpu_reset_o,
   output logic dsp_run_o,
   output logic dsp_cfg_run_o
);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [2:0] clk_on_r;
   logic power_ctrl_on_r;
   logic [ckr_pkg::DLY_W-1:0] restore_delay_count_r;
   logic dsp_cfg_run_r;
   logic dsp_run_r;
   logic global_rst_r;
   logic mpu_rst_r;
   logic flash_pin_r;
   logic [31:0] rdata_r;
   ckr_pkg::ckr_clk_en_t clk_en_r;
   ckr_pkg::ckr_state_t state_r;
   ckr_pkg::ckr_state_t state_nxt;
   logic wr_clk;
   logic wr_pwr;
   logic wr_rst;
   logic soft_global;
   logic timer_start;
   logic timer_busy;
   logic timer_done;
   logic gated_nxt;
   default clocking ckr_cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   assign wr_clk = wr_i && addr_i == ckr_pkg::OFS_IDLE_CLK_EN2;
   assign wr_pwr = wr_i && addr_i == ckr_pkg::OFS_PWR_RESTORE;
   assign wr_rst = wr_i && addr_i == ckr_pkg::OFS_SOFT_RESET;
   assign soft_global = wr_rst && (wdata_i[ckr_pkg::BIT_GLOBAL_SOFT_RESET]
      || (!wdata_i[ckr_pkg::BIT_DSP_RUN]
          && wdata_i[ckr_pkg::BIT_MPU_RESET]));

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   // only defined bits stored
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         clk_on_r <= ckr_pkg::RST_CLK_EN;
      end else if (wr_clk) begin
         clk_on_r <= wdata_i[2:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         power_ctrl_on_r <= ckr_pkg::RST_POWER_CTRL_ON;
         restore_delay_count_r <= ckr_pkg::RST_RESTORE_DELAY;
      end else if (wr_pwr) begin
         power_ctrl_on_r <= wdata_i[ckr_pkg::BIT_POWER_CTRL_ON];
         restore_delay_count_r <= wdata_i[ckr_pkg::DLY_W-1:0];
      end
   end

   // external reset forces config hold
   // external pins win over a software release in the same cycle
   always_ff @(posedge clk_i) begin
      if (!reset_n_i || ext_reset_i) begin
         dsp_cfg_run_r <= ckr_pkg::RST_DSP_CFG_RUN;
      end else if (wr_rst) begin
         dsp_cfg_run_r <= wdata_i[ckr_pkg::BIT_DSP_CFG_RUN];
      end
   end

   // DSP held until software sets run
   always_ff @(posedge clk_i) begin
      if (!reset_n_i || ext_reset_i) begin
         dsp_run_r <= ckr_pkg::RST_DSP_RUN;
      end else if (soft_global) begin
         dsp_run_r <= 1'b0;
      end else if (wr_rst) begin
         dsp_run_r <= wdata_i[ckr_pkg::BIT_DSP_RUN];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         global_rst_r <= 1'b0;
         mpu_rst_r <= 1'b0;
      end else begin
         global_rst_r <= soft_global;
         mpu_rst_r <= wr_rst && wdata_i[ckr_pkg::BIT_MPU_RESET];
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   // reserved reads zero
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= 32'h0000_0000;
         if (rd_i) begin
            unique case (addr_i)
               ckr_pkg::OFS_IDLE_CLK_EN2: begin
                  rdata_r[2:0] <= clk_on_r;
               end
               ckr_pkg::OFS_PWR_RESTORE: begin
                  rdata_r[ckr_pkg::BIT_POWER_CTRL_ON] <= power_ctrl_on_r;
                  rdata_r[ckr_pkg::DLY_W-1:0] <= restore_delay_count_r;
               end
               ckr_pkg::OFS_SOFT_RESET: begin
                  rdata_r[ckr_pkg::BIT_DSP_CFG_RUN] <= dsp_cfg_run_r;
                  rdata_r[ckr_pkg::BIT_DSP_RUN] <= dsp_run_r;
               end
               default: begin
                  rdata_r <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // idle and power-restore sequencing
   // ------------------------------------------------------------
   // pin first, delay, then clocks
   always_comb begin
      state_nxt = state_r;
      timer_start = 1'b0;
      unique case (state_r)
         ckr_pkg::ST_RUN: begin
            if (idle_i) begin
               state_nxt = ckr_pkg::ST_IDLE;
            end
         end
         ckr_pkg::ST_IDLE: begin
            if (!idle_i && !flash_pin_r) begin
               state_nxt = ckr_pkg::ST_RESTORE;
               timer_start = 1'b1;
            end else if (!idle_i) begin
               state_nxt = ckr_pkg::ST_RUN;
            end
         end
         ckr_pkg::ST_RESTORE: begin
            if (timer_done) begin
               state_nxt = ckr_pkg::ST_RUN;
            end
         end
         default: begin
            state_nxt = ckr_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_r <= ckr_pkg::ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // flash pin low in idle unless power control on
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         flash_pin_r <= 1'b1;
      end else begin
         flash_pin_r <= !(state_nxt == ckr_pkg::ST_IDLE && !power_ctrl_on_r);
      end
   end

   ckr_restore_timer #(
      .DW(ckr_pkg::DLY_W)
   ) u_timer (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .start_i(timer_start),
      .count_i(restore_delay_count_r),
      .ref_level_i(memif_ref_clock_i),
      .busy_o(timer_busy),
      .done_o(timer_done)
   );

   // ------------------------------------------------------------
   // clock enables
   // ------------------------------------------------------------
   // idle-selected clocks stay gated through the restore wait so nothing runs on a
   // memory that is still powering up
   assign gated_nxt = state_nxt != ckr_pkg::ST_RUN;

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         clk_en_r <= '{periph: 1'b1, refclk: 1'b0, wdog: 1'b0};
      end else begin
         clk_en_r.periph <= clk_on_r[ckr_pkg::BIT_PERIPH_CLK_ON]
            && !(gated_nxt && idle_sel_i.periph);
         clk_en_r.refclk <= clk_on_r[ckr_pkg::BIT_OSTIMER_REFCLK_ON]
            && !(gated_nxt && idle_sel_i.refclk);
         clk_en_r.wdog <= wdog_mode_i
            || (clk_on_r[ckr_pkg::BIT_WDOG_CLK_ON]
                && !(gated_nxt && idle_sel_i.wdog));
      end
   end

   assign rdata_o = rdata_r;
   assign clk_en_o = clk_en_r;
   assign flash_power_pin_o = flash_pin_r;
   assign global_soft_reset_o = global_rst_r;
   assign mpu_reset_o = mpu_rst_r;
   assign dsp_run_o = dsp_run_r;
   assign dsp_cfg_run_o = dsp_cfg_run_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_one_pulse(sig);
      sig ##1 !sig;
   endsequence

   sequence s_restore_entry;
      state_r == ckr_pkg::ST_IDLE && !idle_i && !flash_pin_r;
   endsequence

   periph_gate_a: assert property (
      !clk_on_r[ckr_pkg::BIT_PERIPH_CLK_ON] |=> !clk_en_r.periph)
      else $error("peripheral clock ran while disabled");

   periph_idle_a: assert property (
      (state_r == ckr_pkg::ST_IDLE && idle_i && idle_sel_i.periph)
      |=> !clk_en_r.periph)
      else $error("peripheral clock not stopped in idle");

   refclk_gate_a: assert property (
      !clk_on_r[ckr_pkg::BIT_OSTIMER_REFCLK_ON] |=> !clk_en_r.refclk)
      else $error("reference clock ran while disabled");

   wdog_gate_a: assert property (
      (!clk_on_r[ckr_pkg::BIT_WDOG_CLK_ON] && !wdog_mode_i)
      |=> !clk_en_r.wdog)
      else $error("watchdog clock ran while disabled");

   wdog_keep_a: assert property (
      wdog_mode_i |=> clk_en_r.wdog)
      else $error("watchdog clock stopped in watchdog mode");

   flash_low_a: assert property (
      (state_r == ckr_pkg::ST_IDLE && idle_i && !power_ctrl_on_r)
      |=> !flash_pin_r)
      else $error("flash pin high in idle without power control");

   global_pulse_a: assert property (
      (wr_rst && wdata_i[ckr_pkg::BIT_GLOBAL_SOFT_RESET])
      |=> s_one_pulse(global_rst_r))
      else $error("global reset not a one-cycle pulse");

   combo_reset_a: assert property (
      (wr_rst && !wdata_i[ckr_pkg::BIT_DSP_RUN]
       && wdata_i[ckr_pkg::BIT_MPU_RESET]) |=> global_rst_r && mpu_rst_r)
      else $error("combined write did not start global reset");

   mpu_pulse_a: assert property (
      (wr_rst && wdata_i[ckr_pkg::BIT_MPU_RESET])
      ##1 !(wr_rst && wdata_i[ckr_pkg::BIT_MPU_RESET])
      |-> s_one_pulse(mpu_rst_r))
      else $error("mpu reset not a one-cycle pulse");

   read_zero_a: assert property (
      (rd_i && addr_i == ckr_pkg::OFS_SOFT_RESET)
      |=> rdata_o[31:3] == 29'h0000_0000 && !rdata_o[0])
      else $error("reserved or pulse bits read nonzero");

   cfg_hold_a: assert property (
      ext_reset_i |=> !dsp_cfg_run_r && !dsp_run_r)
      else $error("external reset did not hold dsp config");

   dsp_hold_a: assert property (
      soft_global |=> !dsp_run_r)
      else $error("dsp left running after global reset");

   restore_seq_a: assert property (
      s_restore_entry |=> flash_pin_r && state_r == ckr_pkg::ST_RESTORE
      && timer_busy && !(clk_en_r.periph && $past(idle_sel_i.periph)))
      else $error("restore did not raise pin before clocks");

endmodule

/* File: testbench/tb_ckr_clock_reset_ctrl.sv */
/*
 * self-checking bench for the clock-enable and soft-reset registers.
 * assumes the design top is ckr_clock_reset_ctrl with its package compiled
 * first; the bench drives every port itself, no far-side model.
 */
`timescale 1ns/10ps
module tb_ckr_clock_reset_ctrl;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic idle = 1'b0;
   ckr_pkg::ckr_idle_sel_t idle_sel = 3'h0;
   logic wdog_mode = 1'b0;
   logic ext_reset = 1'b0;
   logic ref_clk = 1'b0;
   ckr_pkg::ckr_clk_en_t clk_en;
   logic flash_pin, glb_rst, mpu_rst, dsp_run, dsp_cfg_run;
   int err_total = 0;
   int tests_run = 0;
   logic [31:0] lfsr = 32'h0001_7A96;
   logic [31:0] v;

   ckr_clock_reset_ctrl ckr_clock_reset_ctrl_inst (
      .clk_i(clk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .idle_i(idle),
      .idle_sel_i(idle_sel), .wdog_mode_i(wdog_mode),
      .ext_reset_i(ext_reset), .memif_ref_clock_i(ref_clk),
      .clk_en_o(clk_en), .flash_power_pin_o(flash_pin),
      .global_soft_reset_o(glb_rst), .mpu_reset_o(mpu_rst),
      .dsp_run_o(dsp_run), .dsp_cfg_run_o(dsp_cfg_run)
   );

   initial begin
      forever #25 clk = ~clk;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // reserved bits read back as zero in this design
   function automatic logic [31:0] exp_rd(input logic [7:0] a,
                                          input logic [31:0] d);
      if (a == ckr_pkg::OFS_IDLE_CLK_EN2) return d & 32'h7;
      if (a == ckr_pkg::OFS_PWR_RESTORE) return d & 32'h3F;
      return 32'h0;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic test_end(input string name);
      $display("test %s done, mismatches so far %0d", name, err_total);
   endtask

   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // slow reference clock: two cycles low, then two high
   task automatic ref_rise;
      repeat (2) @(posedge clk);
      ref_clk <= 1'b1;
      repeat (2) @(posedge clk);
      ref_clk <= 1'b0;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      finish_test();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      chk({29'h0, clk_en}, 32'h4);
      chk({31'h0, flash_pin}, 32'h1);
      chk({30'h0, dsp_run, dsp_cfg_run}, 32'h0);
      rd_chk(ckr_pkg::OFS_IDLE_CLK_EN2, 32'h4);
      rd_chk(ckr_pkg::OFS_PWR_RESTORE, 32'h3F);
      rd_chk(ckr_pkg::OFS_SOFT_RESET, 32'h0);
      rd_chk(8'h14, 32'h0);
      test_end("reset values");

      // random enables, reserved bits and unmapped writes
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         v = lfsr;
         wr_reg(ckr_pkg::OFS_IDLE_CLK_EN2, v);
         wr_reg(8'h14, ~v);
         rd_chk(ckr_pkg::OFS_IDLE_CLK_EN2, exp_rd(8'h08, v));
         wait_cyc(1);
         chk({29'h0, clk_en}, {29'h0, v[2:0]});
         wr_reg(ckr_pkg::OFS_PWR_RESTORE, ~v);
         rd_chk(ckr_pkg::OFS_PWR_RESTORE, exp_rd(8'h0C, ~v));
      end
      test_end("random enables");

      // watchdog mode overrides a cleared enable and an idle gate
      // power control on so idle exit cannot park in a restore wait
      wr_reg(ckr_pkg::OFS_PWR_RESTORE, 32'h3F);
      wr_reg(ckr_pkg::OFS_IDLE_CLK_EN2, 32'h0);
      wdog_mode <= 1'b1;
      idle_sel <= 3'h1;
      idle <= 1'b1;
      wait_cyc(3);
      chk({29'h0, clk_en}, 32'h1);
      @(posedge clk);
      idle <= 1'b0;
      wdog_mode <= 1'b0;
      wait_cyc(3);
      chk({29'h0, clk_en}, 32'h0);
      test_end("watchdog");

      // software resets
      wr_reg(ckr_pkg::OFS_SOFT_RESET, 32'hFFFF_FFF6);
      wait_cyc(1);
      chk({30'h0, dsp_run, dsp_cfg_run}, 32'h3);
      rd_chk(ckr_pkg::OFS_SOFT_RESET, 32'h6);
      wr_reg(ckr_pkg::OFS_SOFT_RESET, 32'hE);
      @(negedge clk);
      chk({31'h0, glb_rst}, 32'h1);
      @(negedge clk);
      chk({31'h0, glb_rst}, 32'h0);
      chk({31'h0, dsp_run}, 32'h0);
      rd_chk(ckr_pkg::OFS_SOFT_RESET, 32'h4);
      wr_reg(ckr_pkg::OFS_SOFT_RESET, 32'h7);
      @(negedge clk);
      chk({30'h0, glb_rst, mpu_rst}, 32'h1);
      @(negedge clk);
      chk({30'h0, glb_rst, mpu_rst}, 32'h0);
      rd_chk(ckr_pkg::OFS_SOFT_RESET, 32'h6);
      wr_reg(ckr_pkg::OFS_SOFT_RESET, 32'h5);
      @(negedge clk);
      chk({30'h0, glb_rst, mpu_rst}, 32'h3);
      @(negedge clk);
      chk({31'h0, dsp_run}, 32'h0);
      test_end("soft resets");

      // external reset wins over a same-cycle release write
      @(posedge clk);
      ext_reset <= 1'b1;
      addr <= ckr_pkg::OFS_SOFT_RESET;
      wdata <= 32'h6;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      ext_reset <= 1'b0;
      wait_cyc(1);
      chk({30'h0, dsp_run, dsp_cfg_run}, 32'h0);
      test_end("external reset");

      // idle with power control on: only the selected clock stops
      wr_reg(ckr_pkg::OFS_IDLE_CLK_EN2, 32'h7);
      wr_reg(ckr_pkg::OFS_PWR_RESTORE, 32'h23);
      idle_sel <= 3'h4;
      idle <= 1'b1;
      wait_cyc(4);
      chk({28'h0, flash_pin, clk_en}, 32'hB);
      @(posedge clk);
      idle <= 1'b0;
      wait_cyc(2);
      chk({28'h0, flash_pin, clk_en}, 32'hF);
      test_end("idle powered");

      // idle with power control off: pin drops, delayed restart
      wr_reg(ckr_pkg::OFS_PWR_RESTORE, 32'h03);
      idle_sel <= 3'h7;
      idle <= 1'b1;
      wait_cyc(4);
      chk({28'h0, flash_pin, clk_en}, 32'h0);
      @(posedge clk);
      idle <= 1'b0;
      wait_cyc(3);
      chk({28'h0, flash_pin, clk_en}, 32'h8);
      ref_rise();
      ref_rise();
      wait_cyc(6);
      chk({29'h0, clk_en}, 32'h0);
      @(posedge clk);
      ref_clk <= 1'b1;
      @(negedge clk);
      chk({29'h0, clk_en}, 32'h0);
      wait_cyc(2);
      chk({29'h0, clk_en}, 32'h0);
      @(posedge clk);
      ref_clk <= 1'b0;
      @(negedge clk);
      chk({28'h0, flash_pin, clk_en}, 32'hF);
      test_end("power restore");
      finish_test();
   end
endmodule
